// ---- tvsc_i2c_host.sv ----
// behavioural bus controller that writes the serial control registers
`timescale 1ns/1ps

module tvsc_i2c_host (
    // bench clock, used only to pace the bus
    input wire logic clk_i,
    // bus pins: scl is pushed, sda is only ever pulled low
    output logic scl_o,
    output logic sda_low_o,
    input wire logic sda_i,
    // one-cycle mark just after each acknowledge sample
    output logic ack_stb_o
);
    int stretch = 0; // extra low quarters, so the bench can play a slow controller

    // idle bus: scl pushed high, sda released to the pull-up
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        ack_stb_o = 1'b0;
    end

    // n quarters of the 320 ns bus period, ending just after a clock edge
    task automatic quarter(input int n);
        repeat (2 * n) @(posedge clk_i);
        #1;
    endtask : quarter

    // start or repeated start: sda falls while scl is high
    task automatic start();
        sda_low_o = 1'b0;
        quarter(1);
        scl_o = 1'b1;
        quarter(1);
        sda_low_o = 1'b1;
        quarter(1);
        scl_o = 1'b0;
        quarter(1);
    endtask : start

    // stop: sda rises while scl is high, then the bus rests free
    task automatic stop();
        sda_low_o = 1'b1;
        quarter(1);
        scl_o = 1'b1;
        quarter(1);
        sda_low_o = 1'b0;
        quarter(2);
    endtask : stop

    // one bit: data set while scl is low, line sampled late in the high phase
    task automatic one_bit(input logic b, input logic is_ack, output logic seen);
        sda_low_o = ~b;
        quarter(1 + stretch);
        scl_o = 1'b1;
        quarter(2);
        seen = sda_i;
        scl_o = 1'b0;
        ack_stb_o = is_ack;
        @(posedge clk_i);
        #1;
        ack_stb_o = 1'b0;
        @(posedge clk_i);
        #1;
    endtask : one_bit

    // whole byte, most significant bit first, then the acknowledge slot
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            one_bit(b[i], 1'b0, s);
        end
        one_bit(1'b1, 1'b1, s);
        ack = ~s;
    endtask : send_byte
endmodule : tvsc_i2c_host

// ---- tvsc_pkg.sv ----
// constants and types for the tv processor serial control block
package tvsc_pkg;
    // serial bus framing
    localparam logic [7:0] SLAVE_ADDR = 8'h8A;
    localparam logic [3:0] SUB_AUTOINC = 4'h0;
    localparam logic [3:0] SUB_REPEAT = 4'h8;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // control register file
    localparam int REG_COUNT = 13;
    localparam logic [3:0] REG_LIMIT = 4'(REG_COUNT);
    localparam logic [7:0] REG_RST [REG_COUNT] = '{8'h21, 8'h21, 8'h41, 8'h21, 8'h81, 8'h81,
                                                    8'h81, 8'h41, 8'h41, 8'h01, 8'h21, 8'h45,
                                                    8'hC1};
    // register indices
    localparam int IDX_STD = 0;
    localparam int IDX_VERT = 1;
    localparam int IDX_BRIGHT = 2;
    localparam int IDX_CONTRAST = 3;
    localparam int IDX_DRIVE_R = 7;
    localparam int IDX_CHROMA_VCO = 8;
    localparam int IDX_FT_OFFSET = 9;
    localparam int IDX_OUT_SEL = 10;
    localparam int IDX_VIDEO_ADJ = 11;
    localparam int IDX_VISION_IF = 12;
    // single-bit field positions
    localparam int BIT_NTSC = 7;
    localparam int BIT_SECAM_FORCE = 6;
    localparam int BIT_VERT_MANUAL = 7;
    localparam int BIT_TRIG_OFF = 6;
    localparam int BIT_VERT_60 = 7;
    localparam int BIT_SUB_358 = 7;
    localparam int BIT_SIF_SW1 = 7;
    localparam int BIT_SIF_SW2 = 3;
    localparam int BIT_OUT_SEL_HI = 7;
    localparam int BIT_OUT_SEL_LO = 6;
    localparam int BIT_FT_OFFSET_SW = 7;
    // field widths
    localparam int SAT_W = 6;
    localparam int CONTRAST_W = 6;
    localparam int AGC_W = 6;
    localparam int VIF_W = 7;
    localparam int HCTR_W = 3;
    localparam int FT_W = 9;
    // horizontal countdown
    localparam logic [4:0] OSC_LAST = 5'h1F;
    localparam logic [4:0] H_PULSE_W = 5'h0C;
    // vertical countdown and field-rate discrimination, counted in lines
    localparam int LINE_HZ = 15720;
    localparam int FREQ_LO_HZ = 45;
    localparam int FREQ_MID_HZ = 55;
    localparam int FREQ_HI_HZ = 65;
    localparam logic [8:0] LINES_45 = 9'(LINE_HZ / FREQ_LO_HZ);
    localparam logic [8:0] LINES_55 = 9'(LINE_HZ / FREQ_MID_HZ);
    localparam logic [8:0] LINES_65 = 9'(LINE_HZ / FREQ_HI_HZ);
    localparam logic [8:0] FIELD_LINES_50 = 9'h138;
    localparam logic [8:0] FIELD_LINES_60 = 9'h106;
    localparam logic [8:0] V_PULSE_LINES = 9'h00A;
    localparam logic [8:0] MEAS_MAX = 9'h1FF;
    localparam logic [1:0] CONFIRM_LAST = 2'h2;
    // bus phases
    typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_SUB, PH_DATA} tvsc_phase_e;
endpackage : tvsc_pkg

// ---- tvsc_top.sv ----
// serial control register bank, countdown and field-rate discriminator
`timescale 1ns/1ps

module tvsc_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // serial bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_b_o,
    // timing and status pins from the analogue sections
    input wire logic osc_32fh_i,
    input wire logic vsync_i,
    input wire logic killer_active_i,
    input wire logic secam_detect_i,
    input wire logic service_mode_i,
    // deflection outputs
    output logic hpulse_o,
    output logic vpulse_b_o,
    // multiplexed status pin and chroma controls
    output logic status_o,
    output logic chroma_diff_oe_b_o,
    output logic subcarrier_358_o,
    output logic secam_if_carrier_o,
    output logic chroma_en_o,
    output logic ntsc_select_o,
    // analogue settings
    output logic [5:0] contrast_o,
    output logic [6:0] vision_if_vco_o,
    output logic [8:0] fine_tuning_offset_o,
    output logic fine_tuning_defeat_o,
    output logic [5:0] rf_agc_delay_o,
    output logic [1:0] sound_if_sel_o,
    output logic [2:0] h_center_o,
    output logic [103:0] ctrl_regs_o
);

    // two-stage synchronisers, plus a third stage used only for edges
    logic [6:0] meta_q;
    logic [6:0] sync_q;
    logic [6:0] prev_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= 7'h03;
            sync_q <= 7'h03;
            prev_q <= 7'h03;
        end else begin
            meta_q <= {service_mode_i, secam_detect_i, killer_active_i, vsync_i, osc_32fh_i,
                       sda_i, scl_i};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edge and condition decode on synchronised pins
    wire scl_rise = sync_q[0] & ~prev_q[0];
    wire scl_fall = ~sync_q[0] & prev_q[0];
    wire start_det = sync_q[0] & prev_q[0] & prev_q[1] & ~sync_q[1];
    wire stop_det = sync_q[0] & prev_q[0] & ~prev_q[1] & sync_q[1];
    wire osc_rise = sync_q[2] & ~prev_q[2];
    wire vsync_rise = sync_q[3] & ~prev_q[3];
    wire killer_s = sync_q[4];
    wire secam_det_s = sync_q[5];
    wire service_s = sync_q[6];

    // serial slave state
    tvsc_pkg::tvsc_phase_e phase_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic in_ack_q;
    logic sda_oe_b_q;
    logic [3:0] ptr_q;
    logic autoinc_q;

    // byte acceptance decode
    wire byte_done = (bit_cnt_q == tvsc_pkg::BITS_PER_BYTE);
    wire addr_ok = (shift_q == tvsc_pkg::SLAVE_ADDR);
    wire sub_auto = (shift_q[7:4] == tvsc_pkg::SUB_AUTOINC);
    wire sub_rep = (shift_q[7:4] == tvsc_pkg::SUB_REPEAT);
    wire accept = (phase_q == tvsc_pkg::PH_ADDR) ? addr_ok :
                  (phase_q == tvsc_pkg::PH_SUB) ? (sub_auto | sub_rep) : 1'b1;
    wire byte_evt = (phase_q != tvsc_pkg::PH_IDLE) & scl_fall & ~in_ack_q & byte_done;
    wire wr_en = byte_evt & (phase_q == tvsc_pkg::PH_DATA) & (ptr_q < tvsc_pkg::REG_LIMIT);

    // next phase after an accepted byte
    tvsc_pkg::tvsc_phase_e phase_next;
    always_comb begin
        case (phase_q)
            tvsc_pkg::PH_ADDR: phase_next = tvsc_pkg::PH_SUB;
            tvsc_pkg::PH_SUB: phase_next = tvsc_pkg::PH_DATA;
            tvsc_pkg::PH_DATA: phase_next = tvsc_pkg::PH_DATA;
            default: phase_next = tvsc_pkg::PH_IDLE;
        endcase
    end

    // byte receiver; ack is driven from scl fall to the next fall
    // a read address or a foreign address is left unanswered, the bus stays free
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_q <= tvsc_pkg::PH_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            in_ack_q <= 1'b0;
            sda_oe_b_q <= 1'b1;
        end else if (start_det) begin
            phase_q <= tvsc_pkg::PH_ADDR;
            bit_cnt_q <= 4'h0;
            in_ack_q <= 1'b0;
            sda_oe_b_q <= 1'b1;
        end else if (stop_det) begin
            phase_q <= tvsc_pkg::PH_IDLE;
            in_ack_q <= 1'b0;
            sda_oe_b_q <= 1'b1;
        end else if (phase_q != tvsc_pkg::PH_IDLE) begin
            if (scl_rise && !in_ack_q && !byte_done) begin
                shift_q <= {shift_q[6:0], sync_q[1]};
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (scl_fall && in_ack_q) begin
                in_ack_q <= 1'b0;
                sda_oe_b_q <= 1'b1;
                bit_cnt_q <= 4'h0;
            end else if (byte_evt && accept) begin
                in_ack_q <= 1'b1;
                sda_oe_b_q <= 1'b0;
                phase_q <= phase_next;
            end else if (byte_evt) begin
                phase_q <= tvsc_pkg::PH_IDLE;
            end
        end
    end

    // register pointer and its stepping mode
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ptr_q <= 4'h0;
            autoinc_q <= 1'b1;
        end else if (byte_evt && phase_q == tvsc_pkg::PH_SUB && accept) begin
            ptr_q <= shift_q[3:0];
            autoinc_q <= sub_auto;
        end else if (byte_evt && phase_q == tvsc_pkg::PH_DATA && autoinc_q) begin
            ptr_q <= ptr_q + 4'h1;
        end
    end

    // control registers; writes past the last index are acknowledged and dropped
    logic [7:0] regs_q [tvsc_pkg::REG_COUNT];
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < tvsc_pkg::REG_COUNT; i++) begin
                regs_q[i] <= tvsc_pkg::REG_RST[i];
            end
        end else if (wr_en) begin
            regs_q[ptr_q] <= shift_q;
        end
    end

    // horizontal countdown from the 32x line oscillator
    logic [4:0] hcnt_q;
    wire line_en = osc_rise & (hcnt_q == tvsc_pkg::OSC_LAST);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hcnt_q <= 5'h00;
        end else if (osc_rise) begin
            hcnt_q <= hcnt_q + 5'h01;
        end
    end

    // field-rate discriminator: lines between vertical syncs
    logic [8:0] meas_q;
    logic disc_q;
    logic last_j_q;
    logic [1:0] streak_q;
    wire in_range = (meas_q > tvsc_pkg::LINES_65) & (meas_q < tvsc_pkg::LINES_45);
    wire judge60 = (meas_q < tvsc_pkg::LINES_55);
    wire judge_evt = vsync_rise & in_range;
    wire same_j = (judge60 == last_j_q);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meas_q <= 9'h000;
        end else if (vsync_rise) begin
            meas_q <= 9'h000;
        end else if (line_en && meas_q != tvsc_pkg::MEAS_MAX) begin
            meas_q <= meas_q + 9'h001;
        end
    end

    // a judgement out of range breaks the run, so noisy syncs never flip the result
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            disc_q <= 1'b0;
            last_j_q <= 1'b0;
            streak_q <= 2'h0;
        end else if (judge_evt) begin
            last_j_q <= judge60;
            if (same_j && streak_q != tvsc_pkg::CONFIRM_LAST) begin
                streak_q <= streak_q + 2'h1;
            end else if (!same_j) begin
                // a new rate counts its first judgement, so three in a row flip the result
                streak_q <= 2'h1;
            end
            if (same_j && streak_q == tvsc_pkg::CONFIRM_LAST) begin
                disc_q <= judge60;
            end
        end else if (vsync_rise) begin
            streak_q <= 2'h0;
        end
    end

    // selected field rate: automatic or forced from the register
    wire vert_manual = regs_q[tvsc_pkg::IDX_VERT][tvsc_pkg::BIT_VERT_MANUAL];
    wire trig_off = regs_q[tvsc_pkg::IDX_VERT][tvsc_pkg::BIT_TRIG_OFF];
    wire field60 = vert_manual ? regs_q[tvsc_pkg::IDX_BRIGHT][tvsc_pkg::BIT_VERT_60] : disc_q;
    wire [8:0] field_end = (field60 ? tvsc_pkg::FIELD_LINES_60 : tvsc_pkg::FIELD_LINES_50)
                           - 9'h001;
    wire vtrig_take = vsync_rise & ~trig_off;

    // vertical countdown; a trigger restarts it unless triggers are switched off
    logic [8:0] vcnt_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            vcnt_q <= 9'h000;
        end else if (vtrig_take) begin
            vcnt_q <= 9'h000;
        end else if (line_en) begin
            vcnt_q <= (vcnt_q >= field_end) ? 9'h000 : vcnt_q + 9'h001;
        end
    end

    // decoded controls
    wire vblank = (vcnt_q < tvsc_pkg::V_PULSE_LINES);
    wire secam_mode = regs_q[tvsc_pkg::IDX_STD][tvsc_pkg::BIT_SECAM_FORCE] | secam_det_s;
    wire sub_358 = regs_q[tvsc_pkg::IDX_CHROMA_VCO][tvsc_pkg::BIT_SUB_358];
    localparam int SEL_W = 2;
    wire [SEL_W-1:0] out_sel = {regs_q[tvsc_pkg::IDX_OUT_SEL][tvsc_pkg::BIT_OUT_SEL_HI],
                                regs_q[tvsc_pkg::IDX_OUT_SEL][tvsc_pkg::BIT_OUT_SEL_LO]};
    wire status_d = (out_sel == 2'h1) ? ~killer_s :
                    (out_sel == 2'h2) ? secam_det_s : field60;
    wire [tvsc_pkg::FT_W-1:0] ft_off = {
        regs_q[tvsc_pkg::IDX_VISION_IF][tvsc_pkg::BIT_FT_OFFSET_SW],
        regs_q[tvsc_pkg::IDX_FT_OFFSET]};
    wire sat_zero = (regs_q[tvsc_pkg::IDX_STD][tvsc_pkg::SAT_W-1:0] == 6'h00);

    // flattened register image for the analogue dacs and switches
    logic [103:0] regs_flat;
    always_comb begin
        regs_flat = '0;
        for (int i = 0; i < tvsc_pkg::REG_COUNT; i++) begin
            regs_flat[i*8 +: 8] = regs_q[i];
        end
    end

    // every output is registered so pins never glitch on decode
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sda_o <= 1'b0;
            sda_oe_b_o <= 1'b1;
            hpulse_o <= 1'b0;
            vpulse_b_o <= 1'b1;
            status_o <= 1'b0;
            chroma_diff_oe_b_o <= 1'b0;
            subcarrier_358_o <= 1'b0;
            secam_if_carrier_o <= 1'b0;
            chroma_en_o <= 1'b0;
            ntsc_select_o <= 1'b0;
            contrast_o <= 6'h00;
            vision_if_vco_o <= 7'h00;
            fine_tuning_offset_o <= 9'h000;
            fine_tuning_defeat_o <= 1'b0;
            rf_agc_delay_o <= 6'h00;
            sound_if_sel_o <= 2'h0;
            h_center_o <= 3'h0;
            ctrl_regs_o <= '0;
        end else begin
            sda_oe_b_o <= sda_oe_b_q;
            hpulse_o <= (hcnt_q < tvsc_pkg::H_PULSE_W);
            vpulse_b_o <= ~(vblank & ~service_s);
            status_o <= status_d;
            chroma_diff_oe_b_o <= secam_mode;
            subcarrier_358_o <= sub_358;
            secam_if_carrier_o <= secam_mode ? ~vblank : ~sub_358;
            chroma_en_o <= ~sat_zero;
            ntsc_select_o <= regs_q[tvsc_pkg::IDX_STD][tvsc_pkg::BIT_NTSC];
            contrast_o <= service_s ? 6'h00 :
                          regs_q[tvsc_pkg::IDX_CONTRAST][tvsc_pkg::CONTRAST_W-1:0];
            vision_if_vco_o <= regs_q[tvsc_pkg::IDX_VISION_IF][tvsc_pkg::VIF_W-1:0];
            fine_tuning_offset_o <= ft_off;
            fine_tuning_defeat_o <= (ft_off == 9'h000);
            rf_agc_delay_o <= regs_q[tvsc_pkg::IDX_OUT_SEL][tvsc_pkg::AGC_W-1:0];
            sound_if_sel_o <= {regs_q[tvsc_pkg::IDX_DRIVE_R][tvsc_pkg::BIT_SIF_SW1],
                               regs_q[tvsc_pkg::IDX_VIDEO_ADJ][tvsc_pkg::BIT_SIF_SW2]};
            h_center_o <= regs_q[tvsc_pkg::IDX_VIDEO_ADJ][tvsc_pkg::HCTR_W-1:0];
            ctrl_regs_o <= regs_flat;
        end
    end

    // checks on the slave, the discriminator and the mode outputs
    AST_ADDR_NACK: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (byte_evt && phase_q == tvsc_pkg::PH_ADDR && !addr_ok) |=> ##1 (sda_oe_b_o && !in_ack_q))
        else $error("foreign address was acknowledged");
    AST_ADDR_ACK: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (byte_evt && phase_q == tvsc_pkg::PH_ADDR && addr_ok && !start_det && !stop_det)
        |=> (phase_q == tvsc_pkg::PH_SUB) ##1 !sda_oe_b_o)
        else $error("own address not acknowledged");
    AST_AUTOINC: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (byte_evt && phase_q == tvsc_pkg::PH_DATA && autoinc_q) |=> (ptr_q == $past(ptr_q) + 4'h1))
        else $error("pointer did not step");
    AST_REPEAT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (byte_evt && phase_q == tvsc_pkg::PH_DATA && !autoinc_q) |=> $stable(ptr_q))
        else $error("pointer moved in repeat mode");
    AST_HOLD_RANGE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (vsync_rise && !in_range) |=> ($stable(disc_q) && streak_q == 2'h0))
        else $error("result moved on out-of-range field");
    AST_CONFIRM: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (disc_q != $past(disc_q)) |-> ($past(streak_q) == 2'h2 && $past(judge_evt)))
        else $error("result changed before three judgements");
    AST_SECAM_RELEASE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        secam_mode |=> chroma_diff_oe_b_o)
        else $error("colour difference driven in secam");
    AST_SERVICE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        service_s [*2] |=> (contrast_o == 6'h00 && vpulse_b_o))
        else $error("service mode not applied");
    AST_TRIG_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (vsync_rise && trig_off && !line_en) |=> $stable(vcnt_q))
        else $error("trigger taken while switched off");
    AST_CHROMA_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        sat_zero |=> !chroma_en_o)
        else $error("chroma enabled at zero saturation");

endmodule : tvsc_top

// ---- tvsc_top_bench.sv ----
// self-checking bench for the serial control register bank
`timescale 1ns/1ps
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); end end

module tvsc_top_bench;
    // expectation noted by the driving side, consumed by the monitor
    typedef struct {
        int kind;
        logic [103:0] v;
        string what;
    } tvsc_exp_s;
    tvsc_exp_s exp_q[$];
    tvsc_exp_s cur;
    logic [103:0] obs;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic osc = 1'b0, osc_run = 1'b0, vsync = 1'b0;
    logic killer = 1'b0, secam = 1'b0, service = 1'b0, chk_stb = 1'b0;
    wire scl, sda_low, ack_stb, sda_line;
    logic sda_o, sda_oe_b_o, status, cd_oe_b, sc358, chroma_en, ntsc, ft_def;
    logic hpulse, vpulse_b, sc_ifc;
    logic [5:0] contrast, agc;
    logic [6:0] vision_if;
    logic [8:0] ft;
    logic [1:0] sound_if;
    logic [2:0] hc;
    logic [103:0] regs;
    logic [7:0] m [13]; // what the registers should hold
    logic [31:0] rng = 32'h00006042;
    logic [31:0] r;
    int errors = 0, samples_checked = 0, cycles = 0;
    // the control outputs packed for one comparison
    wire [103:0] misc_obs = {62'h0, hpulse, vpulse_b, sc_ifc, status, cd_oe_b, sc358, chroma_en,
        ntsc, contrast, vision_if, ft, ft_def, agc, sound_if, hc};

    // open-drain data line with pull-up: low if either party pulls
    assign sda_line = (sda_low || (!sda_oe_b_o && !sda_o)) ? 1'b0 : 1'b1;

    always #20 clk_i = ~clk_i;

    // fast line-rate oscillator stand-in: one line is 64 clocks
    always @(posedge clk_i) begin
        #1;
        if (osc_run) osc = ~osc;
    end

    tvsc_i2c_host tvsc_i2c_host_inst (.clk_i(clk_i), .scl_o(scl), .sda_low_o(sda_low),
        .sda_i(sda_line), .ack_stb_o(ack_stb));

    tvsc_top tvsc_top_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o), .osc_32fh_i(osc), .vsync_i(vsync),
        .killer_active_i(killer), .secam_detect_i(secam), .service_mode_i(service),
        .hpulse_o(hpulse), .vpulse_b_o(vpulse_b), .status_o(status), .chroma_diff_oe_b_o(cd_oe_b),
        .subcarrier_358_o(sc358), .secam_if_carrier_o(sc_ifc), .chroma_en_o(chroma_en),
        .ntsc_select_o(ntsc), .contrast_o(contrast), .vision_if_vco_o(vision_if),
        .fine_tuning_offset_o(ft), .fine_tuning_defeat_o(ft_def), .rf_agc_delay_o(agc),
        .sound_if_sel_o(sound_if), .h_center_o(hc), .ctrl_regs_o(regs));

    // xorshift source, fixed start so runs repeat
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd

    function automatic logic [103:0] regs_exp();
        logic [103:0] v;
        for (int i = 0; i < 13; i++) v[8*i +: 8] = m[i];
        return v;
    endfunction : regs_exp

    // control outputs worked out from the register image and the status pins
    function automatic logic [103:0] misc_exp(input logic kil, input logic sec, input logic svc);
        logic st;
        logic [8:0] f;
        f = {m[12][7], m[9]};
        case (m[10][7:6])
            2'b01: st = ~kil;
            2'b10: st = sec;
            default: st = 1'b0; // no field has been judged yet, so 50 Hz
        endcase
        // both countdowns rest at zero until the line oscillator runs
        return {62'h0, 1'b1, svc, ~(m[0][6] | sec) & ~m[8][7], st, m[0][6] | sec, m[8][7],
            m[0][5:0] != 6'h00, m[0][7],
            svc ? 6'h00 : m[3][5:0], m[12][6:0], f, f == 9'h000, m[10][5:0], m[7][7],
            m[11][3], m[11][2:0]};
    endfunction : misc_exp

    task automatic note(input int kind, input logic [103:0] v, input string what);
        tvsc_exp_s e;
        e.kind = kind;
        e.v = v;
        e.what = what;
        exp_q.push_back(e);
    endtask : note

    // one byte on the bus with the acknowledge we expect for it
    task automatic xfer(input logic [7:0] b, input logic exp_ack);
        logic a;
        note(0, {103'h0, exp_ack}, "ack");
        tvsc_i2c_host_inst.send_byte(b, a);
    endtask : xfer

    // let outputs settle, then ask the monitor for one comparison
    task automatic check(input int kind, input logic [103:0] v, input string what);
        repeat (8) @(posedge clk_i);
        #1;
        note(kind, v, what);
        chk_stb = 1'b1;
        @(posedge clk_i);
        #1;
        chk_stb = 1'b0;
    endtask : check

    task automatic give_verdict();
        if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    // monitor: the oldest note is compared whenever a result shows
    always @(posedge clk_i) begin
        if (ack_stb || chk_stb) begin
            cur = exp_q.pop_front();
            case (cur.kind)
                0: obs = {103'h0, ~sda_oe_b_o};
                1: obs = regs;
                2: obs = misc_obs;
                default: obs = {103'h0, status};
            endcase
            `CHK(cur.what, cur.v, obs)
        end
    end

    // hang guard, above the roughly 77000 cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            $display("ERROR timeout expected finish seen hang");
            give_verdict();
        end
    end

    initial begin
        for (int i = 0; i < 13; i++) m[i] = tvsc_pkg::REG_RST[i];
        repeat (8) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        repeat (4) @(posedge clk_i);
        check(1, regs_exp(), "reset values");
        // foreign slave bytes, the read form among them, are ignored whole
        foreach (m[i]) if (i < 3) begin
            tvsc_i2c_host_inst.start();
            xfer(i == 0 ? 8'h8B : (i == 1 ? 8'h88 : 8'h0A), 1'b0);
            xfer(8'h00, 1'b0);
            tvsc_i2c_host_inst.stop();
        end
        check(1, regs_exp(), "regs after foreign");
        // full auto-increment loads, covering every sound and status selection
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            killer = r[0];
            secam = r[1];
            service = r[2];
            tvsc_i2c_host_inst.stretch = i % 2;
            for (int k = 0; k < 13; k++) begin
                r = rnd();
                m[k] = r[7:0];
            end
            m[1][7] = 1'b0; // keep the field rate automatic
            if (i < 4) begin
                m[7][7] = i[1];
                m[11][3] = i[0];
                m[10][7:6] = 2'(i);
            end
            if (i == 0) m[0][5:0] = 6'h00;
            if (i == 1) begin
                m[12][7] = 1'b0;
                m[9] = 8'h00;
            end
            tvsc_i2c_host_inst.start();
            xfer(tvsc_pkg::SLAVE_ADDR, 1'b1);
            xfer({tvsc_pkg::SUB_AUTOINC, 4'h0}, 1'b1);
            for (int k = 0; k < 14; k++) xfer(k < 13 ? m[k] : 8'hA5, 1'b1);
            tvsc_i2c_host_inst.stop();
            check(1, regs_exp(), "regs auto step");
            check(2, misc_exp(killer, secam, service), "ctl");
            check(2, misc_exp(killer, secam, service), "hold");
        end
        // repeated writes land in one register
        tvsc_i2c_host_inst.start();
        xfer(tvsc_pkg::SLAVE_ADDR, 1'b1);
        xfer({tvsc_pkg::SUB_REPEAT, 4'h5}, 1'b1);
        for (int k = 0; k < 3; k++) begin
            r = rnd();
            m[5] = r[7:0];
            xfer(m[5], 1'b1);
        end
        // bad sub-address is refused, then a repeated start recovers
        tvsc_i2c_host_inst.start();
        xfer(tvsc_pkg::SLAVE_ADDR, 1'b1);
        xfer(8'h43, 1'b0);
        xfer(8'h77, 1'b0);
        tvsc_i2c_host_inst.start();
        xfer(tvsc_pkg::SLAVE_ADDR, 1'b1);
        xfer({tvsc_pkg::SUB_REPEAT, 4'hC}, 1'b1);
        xfer(8'h5A, 1'b1);
        m[12] = 8'h5A;
        xfer(8'h00, 1'b1);
        m[12] = 8'h00;
        xfer(8'h0A, 1'b1);
        m[12] = 8'h0A;
        tvsc_i2c_host_inst.start();
        xfer(tvsc_pkg::SLAVE_ADDR, 1'b1);
        xfer({tvsc_pkg::SUB_AUTOINC, 4'hA}, 1'b1);
        xfer(8'h00, 1'b1);
        m[10] = 8'h00;
        tvsc_i2c_host_inst.stop();
        check(1, regs_exp(), "regs repeat");
        // field discriminator fed 262-line fields
        service = 1'b0;
        osc_run = 1'b1;
        for (int p = 0; p < 5; p++) begin
            vsync = 1'b1;
            repeat (4) @(posedge clk_i);
            #1;
            vsync = 1'b0;
            if (p == 2 || p == 3) check(3, {103'h0, p == 3}, "rate confirm");
            if (p < 4) repeat (262 * 64 - 4) @(posedge clk_i);
            #1;
        end
        check(3, 104'h1, "rate after four");
        repeat (4) @(posedge clk_i);
        `CHK("queue left", 0, exp_q.size())
        give_verdict();
    end
endmodule : tvsc_top_bench
